// *** logic/dot_matrix_display_host_port.sv ***
`timescale 1ns/100ps
// ************************************************************
// Dot matrix display host port
// ************************************************************
module dot_matrix_display_host_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Host bus.
    input wire dot_display_pkg::host_bus_t bus,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Refresh clock pin.
    input wire logic clock_source_select,
    input wire logic master_clock,
    input wire logic clock_pin_in,
    output logic clock_pin_out,
    output logic clock_pin_oe_n,
    output logic refresh_clock,
    // Display contents for the refresh side.
    output logic [7:0] char_flat [dot_display_pkg::DIGITS],
    output logic [dot_display_pkg::DIGITS-1:0] flash_attr,
    output dot_display_pkg::control_t control
);
    import dot_display_pkg::*;

    logic wr_pulse;
    logic wr_flash;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] char_ram [DIGITS];
    logic [7:0] next_char_ram [DIGITS];
    logic [DIGITS-1:0] flash_ram;
    logic [DIGITS-1:0] next_flash_ram;
    logic [PTR_BITS-1:0] pointer;
    logic [PTR_BITS-1:0] next_pointer;
    logic [DOTS-1:0] glyph_row_ram [GLYPHS*ROWS];
    logic [DOTS-1:0] next_glyph_row_ram [GLYPHS*ROWS];
    logic [7:0] control_word;
    logic [7:0] next_control_word;
    logic [7:0] next_data_out;
    logic next_data_oe_n;
    logic [1:0] wr_section;
    logic [1:0] rd_section;
    logic [2:0] wr_loc;
    logic [2:0] rd_loc;
    logic read_active;
    logic [7:0] glyph_wr_index;
    logic [7:0] glyph_rd_index;

    // ************************************************************
    // Write capture
    // ************************************************************
    write_edge_capture u_capture (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(bus),
        .wr_pulse(wr_pulse),
        .wr_flash(wr_flash),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // Section and location decode for the captured write and live read.
    assign wr_section = wr_addr[4:3];
    assign wr_loc = wr_addr[2:0];
    assign rd_section = bus.addr[4:3];
    assign rd_loc = bus.addr[2:0];
    assign read_active = ~bus.read_n & ~bus.chip_select_n;
    // Glyph row index combines the pointer with the row address.
    assign glyph_wr_index = 8'(pointer) * 8'(ROWS) + 8'(wr_loc);
    assign glyph_rd_index = 8'(pointer) * 8'(ROWS) + 8'(rd_loc);

    // ************************************************************
    // Storage update
    // ************************************************************
    always_comb begin
        next_char_ram = char_ram;
        next_flash_ram = flash_ram;
        next_pointer = pointer;
        next_glyph_row_ram = glyph_row_ram;
        next_control_word = control_word;
        if (wr_pulse) begin
            if (!wr_flash) begin
                // Flash select low ignores the section bits.
                next_flash_ram[wr_loc] = wr_data[FLASH_BIT];
            end else begin
                case (wr_section)
                    SEC_POINTER: begin
                        next_pointer = wr_data[PTR_BITS-1:0];
                    end
                    SEC_GLYPH_ROW: begin
                        // Row code 111 has no row and is dropped.
                        if (wr_loc < 3'(ROWS)) begin
                            next_glyph_row_ram[glyph_wr_index[6:0]] =
                                wr_data[DOTS-1:0];
                        end
                    end
                    SEC_CONTROL: begin
                        next_control_word = wr_data;
                    end
                    SEC_CHAR: begin
                        next_char_ram[wr_loc] = wr_data;
                    end
                    default: begin
                        next_pointer = pointer;
                    end
                endcase
            end
        end
    end

    // Register all storage except the glyph rows.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DIGITS; i++) begin
                char_ram[i] <= CHAR_RESET;
            end
            flash_ram <= '0;
            pointer <= POINTER_RESET;
            control_word <= CONTROL_RESET;
        end else begin
            char_ram <= next_char_ram;
            flash_ram <= next_flash_ram;
            pointer <= next_pointer;
            control_word <= next_control_word;
        end
    end

    // Glyph rows hold no reset state; the host loads them before use.
    always_ff @(posedge clk) begin
        glyph_row_ram <= next_glyph_row_ram;
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        next_data_out = 8'h00;
        next_data_oe_n = ~read_active;
        if (!bus.flash_select_n) begin
            next_data_out = {7'h00, flash_ram[rd_loc]};
        end else begin
            case (rd_section)
                SEC_POINTER: next_data_out = {4'h0, pointer};
                SEC_GLYPH_ROW: begin
                    if (rd_loc < 3'(ROWS)) begin
                        next_data_out = {3'h0,
                            glyph_row_ram[glyph_rd_index[6:0]]};
                    end
                end
                SEC_CONTROL: next_data_out = control_word;
                SEC_CHAR: next_data_out = char_ram[rd_loc];
                default: next_data_out = 8'h00;
            endcase
        end
    end

    // Register the read data and its enable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
        end
    end

    // ************************************************************
    // Refresh clock selection
    // ************************************************************
    assign clock_pin_oe_n = ~clock_source_select;
    assign clock_pin_out = master_clock;
    assign refresh_clock = clock_source_select ? master_clock
                                               : clock_pin_in;

    // ************************************************************
    // Outputs to the refresh logic
    // ************************************************************
    generate
        for (genvar g = 0; g < DIGITS; g++) begin : g_digit
            // Bit 7 flags a glyph entry, else an ASCII code.
            assign char_flat[g] = char_ram[g];
        end
    endgenerate
    assign flash_attr = flash_ram;
    assign control.brightness = control_word[CTRL_BRIGHT_LSB +: 3];
    assign control.flash_enable = control_word[CTRL_FLASH_EN];
    assign control.blink = control_word[CTRL_BLINK];
    assign control.self_test = control_word[CTRL_SELF_TEST];
    assign control.clear = control_word[CTRL_CLEAR];

    // ************************************************************
    // Checks
    // ************************************************************
    a_oe_needs_read: assert property (@(posedge clk) disable iff (sys_rst)
        !data_oe_n |-> $past(read_active))
        else $error("Data bus driven without read and select.");
    a_pointer_load: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pulse && wr_flash && wr_section == SEC_POINTER)
        |=> pointer == $past(wr_data[3:0]))
        else $error("Glyph pointer did not load.");
    a_flash_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pulse && !wr_flash) |=> flash_ram[$past(wr_loc)] ==
        $past(wr_data[0]))
        else $error("Flash bit not stored.");
    a_char_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pulse && wr_flash && wr_section == SEC_CHAR)
        |=> char_ram[$past(wr_loc)] == $past(wr_data))
        else $error("Character entry not stored.");
    a_control_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pulse && wr_flash && wr_section == SEC_CONTROL)
        |=> control_word == $past(wr_data))
        else $error("Control word not stored.");
    a_flash_keeps_char: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_pulse && !wr_flash) |=> $stable(char_ram[0])
        && $stable(control_word))
        else $error("Flash write disturbed another section.");
    a_clock_pin_dir: assert property (@(posedge clk) disable iff (sys_rst)
        clock_source_select |-> !clock_pin_oe_n
        && refresh_clock == master_clock)
        else $error("Internal clock not driven out.");
    a_no_write_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !wr_pulse |=> $stable(pointer) && $stable(flash_ram))
        else $error("Storage changed without a write.");
    a_read_char: assert property (@(posedge clk) disable iff (sys_rst)
        (read_active && bus.flash_select_n && rd_section == SEC_CHAR
        && !wr_pulse) |=> data_out == $past(char_ram[rd_loc]))
        else $error("Character read returned wrong value.");

endmodule : dot_matrix_display_host_port

// *** logic/write_edge_capture.sv ***
`timescale 1ns/100ps
// ************************************************************
// Write strobe capture
// ************************************************************
module write_edge_capture (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Host bus pins.
    input wire dot_display_pkg::host_bus_t bus,
    // Captured write, one-cycle pulse.
    output logic wr_pulse,
    output logic wr_flash,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data
);
    import dot_display_pkg::*;

    logic active;
    logic next_active;
    logic next_pulse;
    logic next_flash;
    logic [4:0] next_addr;
    logic [7:0] next_data;

    // Track the write window and record bus contents while it is open.
    always_comb begin
        next_active = ~bus.write_n & ~bus.chip_select_n;
        next_pulse = active & ~next_active;
        next_flash = wr_flash;
        next_addr = wr_addr;
        next_data = wr_data;
        if (next_active) begin
            // Sample only inside the window, so the last sample taken
            // there is the stored one and the closing edge adds nothing.
            next_flash = bus.flash_select_n;
            next_addr = bus.addr;
            next_data = bus.data;
        end
    end

    // Register the window state and captured values.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            active <= 1'b0;
            wr_pulse <= 1'b0;
            wr_flash <= 1'b1;
            wr_addr <= 5'h00;
            wr_data <= 8'h00;
        end else begin
            active <= next_active;
            wr_pulse <= next_pulse;
            wr_flash <= next_flash;
            wr_addr <= next_addr;
            wr_data <= next_data;
        end
    end

    // A pulse follows the close of a write window by one edge.
    a_pulse_after_end: assert property (@(posedge clk) disable iff (sys_rst)
        (active && !next_active) |=> wr_pulse)
        else $error("Write end did not raise the capture pulse.");

endmodule : write_edge_capture

// *** pkg/dot_display_pkg.sv ***
// Overview of operation
// - Flash select high: A4,A3 choose section.
// - Flash select low: flash RAM, A2-A0 location.
// - Clock source select: 1 internal, 0 external.
// - Internal: drive clock pin; external: input.
// - Write only while write and select low.
// - Drive data only while read, select low.
// - Eight character locations, code 000 leftmost.
// - Data bit 7 picks ASCII or glyph.
// - ASCII code bits 6-0; glyph index 3-0.
// - Glyph pointer low four bits select glyph.
// - Glyph row access uses current glyph pointer.
// - Row from A2-A0, dots from bits 4-0.
// - Bit 0 rightmost column, bit 4 leftmost.
// - Control word holds brightness, flash, blink, test, clear.
// - Flash write stores data bit 0.
package dot_display_pkg;

    // ************************************************************
    // Section decode and field layout
    // ************************************************************
    localparam logic [1:0] SEC_POINTER = 2'h0;
    localparam logic [1:0] SEC_GLYPH_ROW = 2'h1;
    localparam logic [1:0] SEC_CONTROL = 2'h2;
    localparam logic [1:0] SEC_CHAR = 2'h3;
    localparam int TYPE_BIT = 7;
    localparam int FLASH_BIT = 0;
    localparam int DIGITS = 8;
    localparam int GLYPHS = 16;
    localparam int ROWS = 7;
    localparam int DOTS = 5;
    localparam int PTR_BITS = 4;
    localparam logic [7:0] CHAR_RESET = 8'h20;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] POINTER_RESET = 4'h0;
    localparam int CTRL_BRIGHT_LSB = 0;
    localparam int CTRL_FLASH_EN = 3;
    localparam int CTRL_BLINK = 4;
    localparam int CTRL_SELF_TEST = 5;
    localparam int CTRL_CLEAR = 7;

    // Host bus pins as seen by the device.
    typedef struct packed {
        logic chip_select_n;
        logic write_n;
        logic read_n;
        logic flash_select_n;
        logic [4:0] addr;
        logic [7:0] data;
    } host_bus_t;

    // Decoded control word fields.
    typedef struct packed {
        logic [2:0] brightness;
        logic flash_enable;
        logic blink;
        logic self_test;
        logic clear;
    } control_t;

endpackage : dot_display_pkg

// *** testbench/host_model.sv ***
`timescale 1ns/100ps
// ************************************************************
// Host processor on the parallel display bus
// ************************************************************
module host_model (
    // Clock.
    input wire logic clk,
    // Read answer from the device.
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // Host bus pins.
    output dot_display_pkg::host_bus_t bus
);
    import dot_display_pkg::*;

    // The bus starts idle with select and both strobes high.
    initial begin
        bus = '{chip_select_n: 1'b1, write_n: 1'b1, read_n: 1'b1,
                flash_select_n: 1'b1, addr: 5'h00, data: 8'h00};
    end

    // One access: request held for two edges, then select goes high.
    task automatic xfer(input logic fl, input logic [4:0] a,
                        input logic [7:0] d, input logic wr,
                        input logic cs, output logic [7:0] q,
                        output logic oe_n);
        @(posedge clk);
        bus.flash_select_n <= fl;
        bus.addr <= a;
        bus.data <= wr ? d : ~bus.data;
        bus.chip_select_n <= !cs;
        bus.write_n <= !wr;
        bus.read_n <= wr;
        @(posedge clk);
        @(negedge clk);
        q = data_out;
        oe_n = data_oe_n;
        @(posedge clk);
        // Released data no longer shows the written value.
        bus.data <= ~bus.data;
        bus.chip_select_n <= 1'b1;
        bus.write_n <= 1'b1;
        bus.read_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : xfer
endmodule : host_model

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end
// ************************************************************
// Host port testbench
// ************************************************************
module tb;
    import dot_display_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    host_bus_t bus;
    logic [7:0] data_out;
    logic data_oe_n;
    logic clock_source_select = 1'b1;
    logic master_clock = 1'b0;
    logic clock_pin_in = 1'b0;
    logic clock_pin_out, clock_pin_oe_n, refresh_clock;
    logic [7:0] char_flat [DIGITS];
    logic [DIGITS-1:0] flash_attr;
    control_t control;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] q;
    logic oe_n;

    // Free running 125 MHz clock.
    always #4 clk = ~clk;

    dot_matrix_display_host_port DUT (.clk(clk), .sys_rst(sys_rst),
        .bus(bus), .data_out(data_out), .data_oe_n(data_oe_n),
        .clock_source_select(clock_source_select),
        .master_clock(master_clock), .clock_pin_in(clock_pin_in),
        .clock_pin_out(clock_pin_out), .clock_pin_oe_n(clock_pin_oe_n),
        .refresh_clock(refresh_clock), .char_flat(char_flat),
        .flash_attr(flash_attr), .control(control));

    host_model host (.clk(clk), .data_out(data_out),
        .data_oe_n(data_oe_n), .bus(bus));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic fl, input logic [4:0] a,
                      input logic [7:0] d);
        host.xfer(fl, a, d, 1'b1, 1'b1, q, oe_n);
    endtask : wr

    // Reads one place and checks the driven answer.
    task automatic rd_chk(input logic fl, input logic [4:0] a,
                          input logic [7:0] e);
        host.xfer(fl, a, 8'h00, 1'b0, 1'b1, q, oe_n);
        `CHK(oe_n, 1'b0)
        `CHK(q, e)
        `CHK(data_oe_n, 1'b1)
    endtask : rd_chk

    function automatic logic [4:0] dots(int g, int r);
        return 5'(g * 7 + r * 9 + 1);
    endfunction : dots

    // Reset contents as seen at the outputs.
    task automatic test_reset();
        for (int i = 0; i < DIGITS; i++) begin
            `CHK(char_flat[i], CHAR_RESET)
        end
        `CHK(flash_attr, 8'h00)
        `CHK(control, 7'h00)
        `CHK(data_oe_n, 1'b1)
    endtask : test_reset

    // All eight digits written first, then checked, both types.
    task automatic test_char();
        logic [7:0] d;
        for (int i = 0; i < DIGITS; i++) begin
            d = i[0] ? 8'h80 | 8'(i) : 8'h30 + 8'(i);
            wr(1'b1, {2'b11, i[2:0]}, d);
        end
        for (int i = 0; i < DIGITS; i++) begin
            d = i[0] ? 8'h80 | 8'(i) : 8'h30 + 8'(i);
            `CHK(char_flat[i], d)
            rd_chk(1'b1, {2'b11, i[2:0]}, d);
        end
    endtask : test_char

    // Flash writes carry the character decode on A4,A3 yet miss it.
    task automatic test_flash();
        for (int i = 0; i < DIGITS; i++) begin
            wr(1'b0, {2'b11, i[2:0]}, {7'h7F, ~i[0]});
        end
        `CHK(flash_attr, 8'h55)
        `CHK(char_flat[2], 8'h32)
        for (int i = 0; i < DIGITS; i++) begin
            rd_chk(1'b0, {2'b10, i[2:0]}, {7'h00, ~i[0]});
        end
    endtask : test_flash

    // Control word fields follow every write.
    task automatic test_control();
        wr(1'b1, 5'h15, 8'hBD);
        `CHK(control, 7'h5F)
        rd_chk(1'b1, 5'h10, 8'hBD);
        wr(1'b1, 5'h13, 8'h42);
        `CHK(control, 7'h20)
    endtask : test_control

    // Two glyphs loaded by pointer then seven rows each.
    task automatic test_glyph();
        wr(1'b1, 5'h07, 8'hF3);
        rd_chk(1'b1, 5'h02, 8'h03);
        for (int r = 0; r < ROWS; r++) begin
            wr(1'b1, {2'b01, r[2:0]}, {3'h7, dots(3, r)});
        end
        wr(1'b1, 5'h00, 8'h0A);
        for (int r = 0; r < ROWS; r++) begin
            wr(1'b1, {2'b01, r[2:0]}, {3'h0, dots(10, r)});
        end
        rd_chk(1'b1, 5'h0F, 8'h00);
        wr(1'b1, 5'h04, 8'h03);
        for (int r = 0; r < ROWS; r++) begin
            rd_chk(1'b1, {2'b01, r[2:0]}, {3'h0, dots(3, r)});
        end
    endtask : test_glyph

    // Strobes without chip select do nothing.
    task automatic test_guard();
        host.xfer(1'b1, 5'h18, 8'h55, 1'b1, 1'b0, q, oe_n);
        `CHK(char_flat[0], 8'h30)
        host.xfer(1'b1, 5'h18, 8'h00, 1'b0, 1'b0, q, oe_n);
        `CHK(oe_n, 1'b1)
    endtask : test_guard

    // Clock source selection and clock pin direction.
    task automatic test_clock();
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                clock_source_select <= s[0];
                master_clock <= p[0];
                clock_pin_in <= p[1];
                @(negedge clk);
                `CHK(clock_pin_oe_n, ~s[0])
                `CHK(clock_pin_out, p[0])
                `CHK(refresh_clock, s[0] ? p[0] : p[1])
            end
        end
    endtask : test_clock

    // Main sequence: reset, settle, then each scenario.
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        test_reset();
        test_char();
        test_flash();
        test_control();
        test_glyph();
        test_guard();
        test_clock();
        end_sim();
    end

    // Watchdog against a hung access.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : tb
